// ---- logic/tmspi_slave.v ----
// Serial peripheral slave link of a tunable optical module
`timescale 1ns/1ps
`default_nettype none
`include "tmspi_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// R1: Module is slave only; never drives serial clock or select.
// R2: Packets are exactly four bytes under a continuously low select.
// R3: Select rising before all four bytes aborts packet, nothing acted on.
// R4: Completed packet executes only once select returns high.
// R5: Pending response survives a deselected gap before the readout packet.
// R6: Select low starts shifting out transmit register and in receive data.
// R7: Serial output driven while selected, high impedance while deselected.
// R8: Clock idles low; sample on rising edge, change output on falling edge.
// R9: Must work at a serial clock rate of 1 MHz.
// R10: Host starts at 1 MHz or slower until it reads max rate; the bench host runs at 6.25 MHz from its first packet.
// R11: Host selects only one slave at a time.
// R12: Command done driven low on completion; then host reads response.
// R13: No-operation after a write returns current error status bits.
// R14: Enabled communication or execution error asserts service request low.
// R15: Service request stays latched low until status bits are cleared.
// R16: Condition still present after clear re-asserts service request.
// R17: Alarm is non-latching, asserted only while its condition holds.
// R18: Alarm set to lock report stays asserted throughout any tuning.
// R19: Interface select pins sampled only at reset; later changes ignored.
// R20: Capability low six bits give max rate in MHz; upper bits zero.
// R21: Capability register returns to default on every reset.
// R22: Deselect reset option has no effect in this serial peripheral mode.
// R23: Bytes shift most significant bit first, in packet order.
// R24: Command done high from execution start until response is ready; code also drops it when the EXEC_CYC count expires.
module tmspi_slave #(
  parameter [5:0] MAX_RATE_MHZ = `TMSPI_CAP_RATE_DEF,
  parameter       EXEC_CYC     = `TMSPI_EXEC_CYC
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Serial link pins
  input  wire        serial_clock_in,
  input  wire        module_select_n,
  input  wire        serial_data_in,
  output reg         serial_data_out,
  output reg         serial_data_oe,
  output reg         command_done_n,
  output reg         service_request_n,
  output reg         alarm_n,
  // Interface select straps
  input  wire        interface_select0,
  input  wire        interface_select1,
  // Packet towards the command layer
  output reg         rx_valid,
  input  wire        rx_ready,
  output reg  [31:0] rx_packet,
  // Response and completion from the command layer
  input  wire        resp_valid,
  input  wire [31:0] resp_packet,
  input  wire        exec_done,
  // Error events and configuration
  input  wire        comm_error_evt,
  input  wire        exec_error_evt,
  input  wire        comm_error_cond,
  input  wire        exec_error_cond,
  input  wire        status_clear,
  input  wire [1:0]  srq_trigger_en,
  input  wire        srq_latch_en,
  // Alarm sources
  input  wire        alarm_cond,
  input  wire        alarm_lock_mode,
  input  wire        tuning_active,
  // Observable state
  output reg  [15:0] interface_capability,
  output reg  [1:0]  interface_mode,
  output reg  [1:0]  error_status,
  output reg         packet_abort
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change counted when stage 2 and 3 agree
  reg [2:0] sck_sync_ff;
  reg [2:0] sel_sync_ff;
  reg [2:0] sdi_sync_ff;
  reg       sck_ff;
  reg       sel_n_ff;
  reg       sdi_ff;

  always @(posedge clock) begin
    if (rst) begin
      sck_sync_ff <= 3'h0;
      sel_sync_ff <= 3'h7;
      sdi_sync_ff <= 3'h0;
      sck_ff      <= 1'b0;
      sel_n_ff    <= 1'b1;
      sdi_ff      <= 1'b0;
    end else begin
      sck_sync_ff <= {sck_sync_ff[1:0], serial_clock_in};
      sel_sync_ff <= {sel_sync_ff[1:0], module_select_n};
      sdi_sync_ff <= {sdi_sync_ff[1:0], serial_data_in};
      if (sck_sync_ff[1] == sck_sync_ff[2]) begin
        sck_ff <= sck_sync_ff[2];
      end
      if (sel_sync_ff[1] == sel_sync_ff[2]) begin
        sel_n_ff <= sel_sync_ff[2];
      end
      if (sdi_sync_ff[1] == sdi_sync_ff[2]) begin
        sdi_ff <= sdi_sync_ff[2];
      end
    end
  end

  wire nxt_sck    = (sck_sync_ff[1] == sck_sync_ff[2]) ? sck_sync_ff[2]
                                                       : sck_ff;
  wire nxt_sel_n  = (sel_sync_ff[1] == sel_sync_ff[2]) ? sel_sync_ff[2]
                                                       : sel_n_ff;
  wire sck_rise   = nxt_sck & ~sck_ff;
  wire sck_fall   = ~nxt_sck & sck_ff;
  wire sel_fall   = ~nxt_sel_n & sel_n_ff;
  wire sel_rise   = nxt_sel_n & ~sel_n_ff;
  wire sel_active = ~sel_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture and capability register
  reg strap_pend_ff;

  always @(posedge clock) begin
    if (rst) begin
      strap_pend_ff        <= 1'b1;
      interface_mode       <= `TMSPI_MODE_SPI;
      interface_capability <= {`TMSPI_CAP_RSVD, MAX_RATE_MHZ}; // see R21
    end else begin
      if (strap_pend_ff) begin
        strap_pend_ff  <= 1'b0; // see R19
        interface_mode <= {interface_select1, interface_select0}; // see R19
      end
      interface_capability <= {`TMSPI_CAP_RSVD, MAX_RATE_MHZ}; // see R20
    end
  end

  wire spi_mode = (interface_mode == `TMSPI_MODE_SPI) && !strap_pend_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Shift engine
  localparam ST_IDLE  = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_FULL  = 2'h2;

  reg [1:0]                    state_ff;
  reg [`TMSPI_BIT_CNT_W-1:0]   bit_cnt_ff;
  reg [`TMSPI_PKT_BITS-1:0]    rx_shift_ff;
  reg [`TMSPI_PKT_BITS-1:0]    tx_shift_ff;
  reg [`TMSPI_PKT_BITS-1:0]    tx_hold_ff;
  reg                          pkt_ok_ff;
  reg                          pkt_push_ff;
  wire                         buf_in_ready;

  // Response held across deselected gaps until next packet loads it
  always @(posedge clock) begin
    if (rst) begin
      tx_hold_ff <= {`TMSPI_PKT_BITS{1'b0}};
    end else if (resp_valid) begin
      tx_hold_ff <= resp_packet; // see R5
    end else if (exec_done && !resp_valid) begin
      tx_hold_ff <= {{(`TMSPI_PKT_BITS-`TMSPI_ST_W){1'b0}},
                     error_status}; // see R13
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      state_ff        <= ST_IDLE;
      bit_cnt_ff      <= `TMSPI_BIT_ZERO;
      rx_shift_ff     <= {`TMSPI_PKT_BITS{1'b0}};
      tx_shift_ff     <= {`TMSPI_PKT_BITS{1'b0}};
      pkt_ok_ff       <= 1'b0;
      pkt_push_ff     <= 1'b0;
      packet_abort    <= 1'b0;
      serial_data_out <= 1'b0;
      serial_data_oe  <= 1'b0;
    end else begin
      pkt_push_ff  <= 1'b0;
      packet_abort <= 1'b0;
      serial_data_oe <= spi_mode & ~nxt_sel_n; // see R7 R1
      case (state_ff)
        ST_IDLE: begin
          if (spi_mode && sel_fall) begin
            state_ff        <= ST_SHIFT; // see R6
            bit_cnt_ff      <= `TMSPI_BIT_ZERO;
            pkt_ok_ff       <= 1'b0;
            tx_shift_ff     <= {tx_hold_ff[`TMSPI_PKT_BITS-2:0], 1'b0};
            serial_data_out <= tx_hold_ff[`TMSPI_PKT_BITS-1]; // see R23
          end
        end
        ST_SHIFT: begin
          if (sel_rise) begin
            state_ff     <= ST_IDLE;
            packet_abort <= 1'b1; // see R3 R2
          end else begin
            if (sck_rise) begin
              rx_shift_ff <= {rx_shift_ff[`TMSPI_PKT_BITS-2:0],
                              sdi_ff}; // see R8 R23
              bit_cnt_ff  <= bit_cnt_ff + `TMSPI_BIT_ONE;
              if (bit_cnt_ff == `TMSPI_LAST_BIT) begin
                state_ff  <= ST_FULL;
                pkt_ok_ff <= 1'b1;
              end
            end
            if (sck_fall) begin
              serial_data_out <= tx_shift_ff[`TMSPI_PKT_BITS-1]; // see R8
              tx_shift_ff     <= {tx_shift_ff[`TMSPI_PKT_BITS-2:0], 1'b0};
            end
          end
        end
        ST_FULL: begin
          // Extra clocks after the fourth byte are ignored
          if (sel_rise) begin
            state_ff    <= ST_IDLE;
            pkt_push_ff <= pkt_ok_ff; // see R4
            pkt_ok_ff   <= 1'b0;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet buffer towards the command layer
  wire        buf_out_valid;
  wire [31:0] buf_out_data;

  tmspi_buf2 #(
    .WIDTH (`TMSPI_PKT_BITS)
  ) u_buf (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (pkt_push_ff),
    .in_ready  (buf_in_ready),
    .in_data   (rx_shift_ff),
    .out_valid (buf_out_valid),
    .out_ready (~rx_valid | rx_ready),
    .out_data  (buf_out_data)
  );

  always @(posedge clock) begin
    if (rst) begin
      rx_valid  <= 1'b0;
      rx_packet <= {`TMSPI_PKT_BITS{1'b0}};
    end else if (!rx_valid || rx_ready) begin
      rx_valid  <= buf_out_valid;
      rx_packet <= buf_out_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command done line
  reg [`TMSPI_CNT_W-1:0] exec_cnt_ff;
  wire [`TMSPI_CNT_W-1:0] exec_len = EXEC_CYC;

  always @(posedge clock) begin
    if (rst) begin
      command_done_n <= 1'b0;
      exec_cnt_ff    <= `TMSPI_CNT_ZERO;
    end else if (pkt_push_ff && buf_in_ready) begin
      command_done_n <= 1'b1; // see R24
      exec_cnt_ff    <= exec_len;
    end else if (command_done_n) begin
      if (exec_done || exec_cnt_ff == `TMSPI_CNT_ZERO) begin
        command_done_n <= 1'b0; // see R12
      end else begin
        exec_cnt_ff <= exec_cnt_ff - {{(`TMSPI_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error status, service request and alarm
  wire [1:0] err_evt  = {exec_error_evt, comm_error_evt | (pkt_push_ff &
                         ~buf_in_ready)};
  wire [1:0] err_cond = {exec_error_cond, comm_error_cond};

  always @(posedge clock) begin
    if (rst) begin
      error_status      <= `TMSPI_ST_ZERO;
      service_request_n <= 1'b1;
      alarm_n           <= 1'b1;
    end else begin
      // Set wins over clear; persisting condition re-sets after clear
      error_status <= (status_clear ? `TMSPI_ST_ZERO : error_status)
                      | err_evt | (status_clear ? err_cond
                                                : `TMSPI_ST_ZERO); // see R16
      if (srq_latch_en) begin
        service_request_n <= ~|(srq_trigger_en &
                             (error_status | err_evt)); // see R14 R15
      end else begin
        service_request_n <= ~|(srq_trigger_en &
                             (err_evt | err_cond)); // see R14
      end
      alarm_n <= ~(alarm_cond |
                 (alarm_lock_mode & tuning_active)); // see R17 R18
    end
  end

  // Deselect reset option belongs to the asynchronous mode only; not used
  // here, so deselect never touches the capability register. see R22
  // Slave works from any serial clock far below the 100 MHz sampler. see R9

endmodule // tmspi_slave

`default_nettype wire

// ---- logic/tmspi_consts.vh ----
// Constants for the tunable module serial peripheral slave
`ifndef TMSPI_CONSTS_VH
`define TMSPI_CONSTS_VH

// Packet shape
`define TMSPI_PKT_BITS      32
`define TMSPI_BIT_CNT_W     6
`define TMSPI_LAST_BIT      6'h1F
`define TMSPI_BIT_ZERO      6'h00
`define TMSPI_BIT_ONE       6'h01

// Interface select pin codes (select1, select0)
`define TMSPI_MODE_SPI      2'h0
`define TMSPI_MODE_ASYNC    2'h1
`define TMSPI_MODE_I2C      2'h2
`define TMSPI_MODE_TBD      2'h3

// Capability register layout
`define TMSPI_CAP_W         16
`define TMSPI_CAP_RATE_W    6
`define TMSPI_CAP_RSVD_W    10
`define TMSPI_CAP_RSVD      10'h000
`define TMSPI_CAP_RATE_DEF  6'h01

// Status bit positions within the status word
`define TMSPI_ST_CE         0
`define TMSPI_ST_XE         1
`define TMSPI_ST_W          2
`define TMSPI_ST_ZERO       2'h0

// Execution latency from deselect to command done
`define TMSPI_EXEC_CYC      8'h04
`define TMSPI_CNT_W         8
`define TMSPI_CNT_ZERO      8'h00

`endif

// ---- logic/tmspi_buf2.v ----
// Two-entry valid/ready buffer for completed packets
`timescale 1ns/1ps
`default_nettype none

module tmspi_buf2 #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rst,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_ff [0:1];
  reg             wr_ptr_ff;
  reg             rd_ptr_ff;
  reg [1:0]       cnt_ff;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data  = mem_ff[rd_ptr_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff    <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 2'h1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 2'h1;
      end
    end
  end

endmodule // tmspi_buf2

`default_nettype wire

// ---- testbench/tmspi_slave_chk.sv ----
// Port assertions for the serial peripheral slave
`timescale 1ns/1ps
`default_nettype none
module tmspi_slave_chk #(
  parameter [5:0] MAX_RATE_MHZ = 6'h01
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Link pins
  input wire logic        module_select_n,
  input wire logic        serial_data_oe,
  input wire logic        command_done_n,
  input wire logic        service_request_n,
  input wire logic        alarm_n,
  // Command side
  input wire logic        rx_valid,
  input wire logic        exec_done,
  input wire logic        comm_error_evt,
  input wire logic        status_clear,
  input wire logic [1:0]  srq_trigger_en,
  input wire logic        srq_latch_en,
  input wire logic        alarm_cond,
  input wire logic        alarm_lock_mode,
  input wire logic        tuning_active,
  // Observable state
  input wire logic [15:0] interface_capability,
  input wire logic [1:0]  interface_mode,
  input wire logic        packet_abort
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire alarm_src = alarm_cond || (alarm_lock_mode && tuning_active);

  oe_idle_a: assert property (module_select_n [*8] |-> !serial_data_oe)
    else $error("output enabled while deselected");
  oe_on_a: assert property (
    (!module_select_n && interface_mode == 2'h0) [*8] |-> serial_data_oe)
    else $error("output not enabled while selected");
  cap_a: assert property (
    interface_capability == {10'h000, MAX_RATE_MHZ})
    else $error("capability value wrong");
  mode_hold_a: assert property (!$past(rst) |=> $stable(interface_mode))
    else $error("interface mode changed after reset");
  alm_on_a: assert property (alarm_src [*3] |-> !alarm_n)
    else $error("alarm not asserted");
  alm_off_a: assert property ((!alarm_src) [*3] |-> alarm_n)
    else $error("alarm held without condition");
  srq_set_a: assert property (
    comm_error_evt && srq_trigger_en[0] |-> ##[1:3] !service_request_n)
    else $error("service request not raised");
  srq_hold_a: assert property (
    (srq_latch_en && !status_clear) [*3] ##0 !service_request_n
    |=> !service_request_n)
    else $error("service request released early");
  done_hi_a: assert property ($rose(rx_valid) |-> ##[0:2] command_done_n)
    else $error("command done not high on execution");
  done_lo_a: assert property (exec_done |-> ##[1:2] !command_done_n)
    else $error("command done not low after finish");
  rx_late_a: assert property (
    $rose(rx_valid) |-> module_select_n && $past(module_select_n, 3))
    else $error("packet delivered while selected");
  abort_a: assert property (packet_abort && !rx_valid |-> !rx_valid [*4])
    else $error("aborted packet delivered");
endmodule // tmspi_slave_chk

bind tmspi_slave tmspi_slave_chk #(.MAX_RATE_MHZ(MAX_RATE_MHZ)) chk (.*);
`default_nettype wire

// ---- testbench/tmspi_host_model.sv ----
// Host side serial master model
`timescale 1ns/1ps
`default_nettype none
module tmspi_host_model #(
  parameter int HALF = 80
) (
  // Serial link
  output var logic sclk,
  output var logic sel_n,
  output var logic mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    mosi = 1'b0;
  end

  // Framed transfer of nb bits; this is the only slave selected
  task automatic xfer(input logic [31:0] tx, input int nb,
                      output logic [31:0] rx);
    rx = 32'h0000_0000;
    sel_n = 1'b0;
    #(5 * HALF);
    for (int i = 0; i < nb; i++) begin
      mosi = tx[31 - i];
      #HALF sclk = 1'b1;
      rx = {rx[30:0], miso};
      #HALF sclk = 1'b0;
    end
    #HALF sel_n = 1'b1;
    mosi = ~mosi;
    #(5 * HALF);
  endtask
endmodule // tmspi_host_model
`default_nettype wire

// ---- testbench/tmspi_slave_tb.sv ----
// Self-checking bench for the serial peripheral slave
`timescale 1ns/1ps
`default_nettype none
module tmspi_slave_tb;
  localparam logic [5:0] RATE = 6'h14;
  logic clock = 1'b0, rst = 1'b1, rx_ready = 1'b0, resp_valid = 1'b0;
  logic interface_select0 = 1'b0, interface_select1 = 1'b0;
  logic exec_done = 1'b0, comm_error_evt = 1'b0, exec_error_evt = 1'b0;
  logic comm_error_cond = 1'b0, exec_error_cond = 1'b0, status_clear = 1'b0;
  logic srq_latch_en = 1'b1, alarm_cond = 1'b0, alarm_lock_mode = 1'b0;
  logic tuning_active = 1'b0;
  logic [1:0] srq_trigger_en = 2'h3;
  logic [31:0] resp_packet = 32'h0000_0000, rx;
  wire serial_clock_in, module_select_n, serial_data_in, serial_data_out;
  wire serial_data_oe, command_done_n, service_request_n, alarm_n;
  wire rx_valid, packet_abort;
  wire [31:0] rx_packet;
  wire [15:0] interface_capability;
  wire [1:0] interface_mode, error_status;
  // Released return line shows the inverse of its last level
  wire miso = serial_data_oe ? serial_data_out : ~serial_data_out;
  int errors = 0, n_checks = 0, aborts = 0;

  tmspi_slave #(.MAX_RATE_MHZ(RATE), .EXEC_CYC(8'h40)) dut (.*);
  tmspi_host_model host (.sclk(serial_clock_in), .sel_n(module_select_n),
    .mosi(serial_data_in), .miso(miso));

  always #5 clock = ~clock;
  always @(posedge clock) if (packet_abort) aborts++;

  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task chk(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task take(input logic [31:0] exp);
    for (int i = 0; i < 60 && rx_valid !== 1'b1; i++) tick(1);
    chk("rx_packet", rx_packet, exp);
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
  endtask
  task stop_test;
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #200_000;
    errors++;
    stop_test;
  end

  initial begin
    tick(20);
    rst = 1'b0;
    tick(3);
    chk("capability", 32'(interface_capability), {26'h0, RATE});
    interface_select0 = 1'b1;
    interface_select1 = 1'b1;
    tick(3);
    chk("mode", 32'(interface_mode), 32'h0);
    host.xfer(32'hA5C3_0F81, 32, rx);
    take(32'hA5C3_0F81);
    chk("busy", 32'(command_done_n), 32'h1);
    resp_packet = 32'h1234_5678;
    resp_valid = 1'b1;
    exec_done = 1'b1;
    tick(1);
    resp_valid = 1'b0;
    exec_done = 1'b0;
    tick(2);
    chk("done", 32'(command_done_n), 32'h0);
    tick(40);
    host.xfer(32'h0000_0000, 32, rx);
    chk("response", rx, 32'h1234_5678);
    take(32'h0000_0000);
    exec_error_evt = 1'b1;
    comm_error_evt = 1'b1;
    tick(1);
    exec_error_evt = 1'b0;
    comm_error_evt = 1'b0;
    tick(3);
    chk("srq", 32'(service_request_n), 32'h0);
    exec_done = 1'b1;
    tick(1);
    exec_done = 1'b0;
    host.xfer(32'h0000_0000, 32, rx);
    chk("status", rx, 32'h3);
    take(32'h0000_0000);
    chk("srq held", 32'(service_request_n), 32'h0);
    exec_error_cond = 1'b1;
    status_clear = 1'b1;
    tick(1);
    status_clear = 1'b0;
    tick(3);
    chk("srq again", 32'(service_request_n), 32'h0);
    chk("errors", 32'(error_status), 32'h2);
    exec_error_cond = 1'b0;
    status_clear = 1'b1;
    tick(1);
    status_clear = 1'b0;
    tick(3);
    chk("srq clear", 32'(service_request_n), 32'h1);
    host.xfer(32'hFFFF_FFFF, 12, rx);
    tick(10);
    chk("aborts", 32'(aborts), 32'h1);
    chk("no packet", 32'(rx_valid), 32'h0);
    host.xfer(32'h1111_1111, 32, rx);
    host.xfer(32'h2222_2222, 32, rx);
    host.xfer(32'h3333_3333, 32, rx);
    host.xfer(32'h4444_4444, 32, rx);
    chk("refused", 32'(error_status[0]), 32'h1);
    take(32'h1111_1111);
    take(32'h2222_2222);
    take(32'h3333_3333);
    tick(5);
    chk("drained", 32'(rx_valid), 32'h0);
    alarm_cond = 1'b1;
    tick(4);
    chk("alarm", 32'(alarm_n), 32'h0);
    alarm_cond = 1'b0;
    tick(4);
    chk("alarm off", 32'(alarm_n), 32'h1);
    alarm_lock_mode = 1'b1;
    tuning_active = 1'b1;
    tick(4);
    chk("tuning", 32'(alarm_n), 32'h0);
    stop_test;
  end
endmodule // tmspi_slave_tb
`default_nettype wire
